// ### logic/aab_burst_ctrl.sv
// accumulator, result formatting and burst power-up sequencing
`timescale 1ns/100ps
module aab_burst_ctrl (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire aab_pkg::aab_sfr_req_t  sfrReq,
  output logic      [7:0]             sfrRdata,
  input  wire logic                   burstModeEnable,
  input  wire logic                   converterEnable,
  input  wire logic                   socPulse,
  input  wire aab_pkg::aab_conv_res_t convRes,
  output logic                        convStart,
  output logic                        firstOfBurst,
  output logic                        convPowered,
  output logic                        lowPowerModeEnable,
  output logic                        twelveBitModeEnable
);
  typedef struct packed {
    aab_pkg::aab_state_t state;
    logic [7:0]          accCfg;
    logic [7:0]          pwrTime;
    logic [15:0]         acc;
    logic [7:0]          rdata;
    logic [5:0]          tick;
    logic [3:0]          pwrCnt;
    logic [6:0]          convLeft;
    logic                convStart;
    logic                first;
    logic                powered;
  } aab_ctrl_state_t;

  aab_ctrl_state_t st_ff;
  aab_ctrl_state_t nxt_st;
  logic [15:0]     fmtWord;
  logic [2:0]      rptCode;
  logic [6:0]      rptNum;
  logic            cfgHit;
  logic            pwrHit;
  logic            hiHit;
  logic            loHit;
  logic            accLoad;

  aab_result_fmt u_fmt (
    .accWord   (st_ff.acc),
    .sjSel     (st_ff.accCfg[aab_pkg::SJ_HI:aab_pkg::SJ_LO]),
    .twelveBit (st_ff.accCfg[aab_pkg::TWELVE_BIT]),
    .fmtWord   (fmtWord)
  );

  always_comb begin
    cfgHit = sfrReq.page == aab_pkg::PAGE_MAIN &&
             sfrReq.addr == aab_pkg::ADDR_ACC_CFG;
    pwrHit = sfrReq.page == aab_pkg::PAGE_ALT &&
             sfrReq.addr == aab_pkg::ADDR_PWR_TIME;
    hiHit  = sfrReq.page == aab_pkg::PAGE_MAIN &&
             sfrReq.addr == aab_pkg::ADDR_RES_HI;
    loHit  = sfrReq.page == aab_pkg::PAGE_MAIN &&
             sfrReq.addr == aab_pkg::ADDR_RES_LO;
    rptCode = st_ff.accCfg[aab_pkg::RPT_HI:aab_pkg::RPT_LO];
    if (rptCode == 3'h0 || rptCode > aab_pkg::RPT_MAX) begin
      rptNum = 7'h01;
    end else begin
      rptNum = 7'(7'h01 << (rptCode + 3'h1));
    end
    // load or add, burst loads its first sample
    accLoad = burstModeEnable ? st_ff.first
                              : !st_ff.accCfg[aab_pkg::ACC_EN];
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.convStart = 1'b0;
    if (sfrReq.wrEn && cfgHit) begin
      nxt_st.accCfg = sfrReq.wdata;
    end
    if (sfrReq.wrEn && pwrHit) begin
      nxt_st.pwrTime = sfrReq.wdata & aab_pkg::PWR_WR_MASK;
    end
    if (sfrReq.rdEn) begin
      if (cfgHit) begin
        nxt_st.rdata = st_ff.accCfg & aab_pkg::CFG_RD_MASK;
      end else if (pwrHit) begin
        nxt_st.rdata = st_ff.pwrTime;
      end else if (hiHit) begin
        nxt_st.rdata = fmtWord[15:8];
      end else if (loHit) begin
        nxt_st.rdata = fmtWord[7:0];
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
    case (st_ff.state)
      aab_pkg::ST_IDLE: begin
        if (socPulse) begin
          if (burstModeEnable) begin
            nxt_st.first = 1'b1;
            nxt_st.convLeft = rptNum;
            if (converterEnable || st_ff.powered) begin
              nxt_st.state = aab_pkg::ST_CONV;
              nxt_st.convStart = 1'b1;
            end else begin
              nxt_st.state = aab_pkg::ST_PWRUP;
              nxt_st.tick = 6'h00;
              nxt_st.pwrCnt = 4'h0;
            end
          end else if (converterEnable) begin
            nxt_st.first = 1'b0;
            nxt_st.convLeft = 7'h01;
            nxt_st.state = aab_pkg::ST_CONV;
            nxt_st.convStart = 1'b1;
          end
        end
      end
      aab_pkg::ST_PWRUP: begin
        if (st_ff.tick == aab_pkg::STEP_LAST) begin
          nxt_st.tick = 6'h00;
          nxt_st.pwrCnt = st_ff.pwrCnt + 4'h1;
          if (st_ff.pwrCnt ==
              st_ff.pwrTime[aab_pkg::PWR_HI:aab_pkg::PWR_LO]) begin
            nxt_st.state = aab_pkg::ST_CONV;
            nxt_st.convStart = 1'b1;
          end
        end else begin
          nxt_st.tick = st_ff.tick + 6'h01;
        end
      end
      aab_pkg::ST_CONV: begin
        if (convRes.done) begin
          nxt_st.first = 1'b0;
          nxt_st.acc = accLoad ? {4'h0, convRes.data}
                               : st_ff.acc + {4'h0, convRes.data};
          nxt_st.convLeft = st_ff.convLeft - 7'h01;
          if (st_ff.convLeft > 7'h01) begin
            nxt_st.convStart = 1'b1;
          end else begin
            nxt_st.state = aab_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        nxt_st.state = aab_pkg::ST_IDLE;
      end
    endcase
    if (sfrReq.wrEn && hiHit) begin
      nxt_st.acc[15:8] = sfrReq.wdata;
    end
    if (sfrReq.wrEn && loHit) begin
      nxt_st.acc[7:0] = sfrReq.wdata;
    end
    nxt_st.powered = burstModeEnable
      ? (converterEnable || nxt_st.state != aab_pkg::ST_IDLE)
      : converterEnable;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{state: aab_pkg::ST_IDLE, accCfg: aab_pkg::ACC_CFG_RST,
                 pwrTime: aab_pkg::PWR_TIME_RST, acc: aab_pkg::ACC_RST,
                 rdata: 8'h00, tick: 6'h00, pwrCnt: 4'h0,
                 convLeft: 7'h00, convStart: 1'b0, first: 1'b0,
                 powered: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sfrRdata            = st_ff.rdata;
  assign convStart           = st_ff.convStart;
  assign firstOfBurst        = st_ff.first;
  assign convPowered         = st_ff.powered;
  assign lowPowerModeEnable  = st_ff.pwrTime[aab_pkg::LPM_BIT];
  assign twelveBitModeEnable = st_ff.accCfg[aab_pkg::TWELVE_BIT];

  // power-up dwell counter for checking
  logic [10:0] puCycles_ff;
  always_ff @(posedge clk) begin
    if (sys_rst || st_ff.state != aab_pkg::ST_PWRUP) begin
      puCycles_ff <= 11'h000;
    end else begin
      puCycles_ff <= puCycles_ff + 11'h001;
    end
  end

  property p_twelve_bit;
    @(posedge clk) disable iff (sys_rst)
    sfrReq.wrEn && cfgHit |=>
      twelveBitModeEnable == $past(sfrReq.wdata[aab_pkg::TWELVE_BIT]);
  endproperty
  a_twelve_bit: assert property (p_twelve_bit)
    else $error("twelve-bit enable not taken from write");

  property p_latest_only;
    @(posedge clk) disable iff (sys_rst)
    st_ff.state == aab_pkg::ST_CONV && convRes.done && !burstModeEnable &&
    !st_ff.accCfg[aab_pkg::ACC_EN] && !sfrReq.wrEn
      |=> st_ff.acc == {4'h0, $past(convRes.data)};
  endproperty
  a_latest_only: assert property (p_latest_only)
    else $error("result not replaced by latest conversion");

  property p_clear_low;
    @(posedge clk) disable iff (sys_rst)
    sfrReq.wrEn && loHit && sfrReq.wdata == 8'h00 |=> st_ff.acc[7:0] == 8'h00;
  endproperty
  a_clear_low: assert property (p_clear_low)
    else $error("low result byte not cleared by zero write");

  property p_ae_reads_zero;
    @(posedge clk) disable iff (sys_rst)
    sfrReq.rdEn && cfgHit |=> !sfrRdata[aab_pkg::ACC_EN];
  endproperty
  a_ae_reads_zero: assert property (p_ae_reads_zero)
    else $error("accumulate enable visible on read");

  property p_unused_zero;
    @(posedge clk) disable iff (sys_rst)
    sfrReq.rdEn && pwrHit |=> sfrRdata[6:4] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused power-up bits read nonzero");

  property p_power_follows;
    @(posedge clk) disable iff (sys_rst)
    !burstModeEnable |=> convPowered == $past(converterEnable);
  endproperty
  a_power_follows: assert property (p_power_follows)
    else $error("power does not follow converter enable");

  property p_immediate;
    @(posedge clk) disable iff (sys_rst)
    st_ff.state == aab_pkg::ST_IDLE && socPulse && burstModeEnable &&
    converterEnable |=> convStart && firstOfBurst;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("burst with enable did not start at once");

  sequence s_cold_soc;
    st_ff.state == aab_pkg::ST_IDLE && socPulse && burstModeEnable &&
    !converterEnable && !convPowered;
  endsequence
  sequence s_waiting;
    !convStart [*8];
  endsequence
  property p_cold_wait;
    @(posedge clk) disable iff (sys_rst)
    s_cold_soc |=> s_waiting;
  endproperty
  a_cold_wait: assert property (p_cold_wait)
    else $error("cold burst started without power-up delay");

  property p_delay_len;
    @(posedge clk) disable iff (sys_rst)
    st_ff.state == aab_pkg::ST_PWRUP && nxt_st.state != aab_pkg::ST_PWRUP
      |-> 32'(puCycles_ff) + 1 ==
          (32'(st_ff.pwrTime[aab_pkg::PWR_HI:aab_pkg::PWR_LO]) + 1)
          * aab_pkg::PWR_STEP_CYC;
  endproperty
  a_delay_len: assert property (p_delay_len)
    else $error("power-up delay length wrong");

  property p_first_after_pwr;
    @(posedge clk) disable iff (sys_rst)
    st_ff.state == aab_pkg::ST_PWRUP ##1 st_ff.state == aab_pkg::ST_CONV
      |-> convStart && firstOfBurst;
  endproperty
  a_first_after_pwr: assert property (p_first_after_pwr)
    else $error("first burst conversion not started after power-up");
endmodule // aab_burst_ctrl

// ### logic/aab_pkg.sv
// shared constants and types for the accumulator and burst power control
package aab_pkg;
  // register addresses and pages
  localparam logic [7:0] ADDR_ACC_CFG  = 8'hBA;
  localparam logic [7:0] ADDR_PWR_TIME = 8'hBA;
  localparam logic [7:0] ADDR_RES_HI   = 8'hBE;
  localparam logic [7:0] ADDR_RES_LO   = 8'hBD;
  localparam logic [3:0] PAGE_MAIN     = 4'h0;
  localparam logic [3:0] PAGE_ALT      = 4'hF;
  // reset values
  localparam logic [7:0]  ACC_CFG_RST  = 8'h00;
  localparam logic [7:0]  PWR_TIME_RST = 8'h0F;
  localparam logic [15:0] ACC_RST      = 16'h0000;
  // field positions
  localparam int TWELVE_BIT = 7;
  localparam int ACC_EN     = 6;
  localparam int SJ_HI      = 5;
  localparam int SJ_LO      = 3;
  localparam int RPT_HI     = 2;
  localparam int RPT_LO     = 0;
  localparam int LPM_BIT    = 7;
  localparam int PWR_HI     = 3;
  localparam int PWR_LO     = 0;
  localparam logic [7:0] PWR_WR_MASK = 8'h8F;
  localparam logic [7:0] CFG_RD_MASK = 8'hBF;
  // shift, justify and repeat codes
  localparam logic [2:0] SJ_LEFT    = 3'h4;
  localparam logic [2:0] SJ_MAX_RT  = 3'h3;
  localparam logic [2:0] RPT_MAX    = 3'h5;
  localparam logic [3:0] LJ_SHIFT12 = 4'h4;
  localparam logic [3:0] LJ_SHIFT10 = 4'h6;
  // power-up timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PWR_STEP_NS   = 400;
  localparam int PWR_STEP_CYC  =
    (PWR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] STEP_LAST = 6'(PWR_STEP_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PWRUP,
    ST_CONV
  } aab_state_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aab_sfr_req_t;

  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } aab_conv_res_t;
endpackage

// ### logic/aab_result_fmt.sv
// shift and justify formatter for the 16-bit accumulator read path
`timescale 1ns/100ps
module aab_result_fmt (
  input  wire logic [15:0] accWord,
  input  wire logic [2:0]  sjSel,
  input  wire logic        twelveBit,
  output logic      [15:0] fmtWord
);
  always_comb begin
    if (sjSel <= aab_pkg::SJ_MAX_RT) begin
      fmtWord = accWord >> sjSel;
    end else if (sjSel == aab_pkg::SJ_LEFT) begin
      fmtWord = accWord << (twelveBit ? aab_pkg::LJ_SHIFT12
                                      : aab_pkg::LJ_SHIFT10);
    end else begin
      fmtWord = accWord;
    end
  end
endmodule // aab_result_fmt

// ### sim/tb_aab_burst_ctrl.sv
// self-checking bench for the accumulator and burst power control
`timescale 1ns/100ps
module tb_aab_burst_ctrl;
  logic                   clk;
  logic                   sys_rst;
  aab_pkg::aab_sfr_req_t  sfrReq;
  logic [7:0]             sfrRdata;
  logic                   burstModeEnable;
  logic                   converterEnable;
  logic                   socPulse;
  aab_pkg::aab_conv_res_t convRes;
  logic                   convStart;
  logic                   firstOfBurst;
  logic                   convPowered;
  logic                   lowPowerModeEnable;
  logic                   twelveBitModeEnable;
  int                     err_total;
  int                     n_compared;
  int                     nWait;
  logic [15:0]            accRd;

  aab_burst_ctrl u_dut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .sfrReq              (sfrReq),
    .sfrRdata            (sfrRdata),
    .burstModeEnable     (burstModeEnable),
    .converterEnable     (converterEnable),
    .socPulse            (socPulse),
    .convRes             (convRes),
    .convStart           (convStart),
    .firstOfBurst        (firstOfBurst),
    .convPowered         (convPowered),
    .lowPowerModeEnable  (lowPowerModeEnable),
    .twelveBitModeEnable (twelveBitModeEnable)
  );

  always #4 clk = ~clk;

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle strobe; read data is in sfrRdata on return
  task automatic bus(input logic wr, input logic [3:0] pg,
                     input logic [7:0] ad, input logic [7:0] wd);
    step();
    sfrReq = '{wrEn: wr, rdEn: ~wr, page: pg, addr: ad, wdata: wd};
    step();
    sfrReq = '0;
  endtask

  task automatic rdAcc();
    bus(1'b0, 4'h0, 8'hBE, 8'h00);
    accRd[15:8] = sfrRdata;
    bus(1'b0, 4'h0, 8'hBD, 8'h00);
    accRd[7:0] = sfrRdata;
  endtask

  task automatic soc();
    step();
    socPulse = 1'b1;
    step();
    socPulse = 1'b0;
  endtask

  task automatic waitStart();
    nWait = 0;
    while (convStart !== 1'b1 && nWait < 1000) begin
      step();
      nWait++;
    end
  endtask

  task automatic done(input logic [11:0] d);
    step();
    convRes = '{done: 1'b1, data: d};
    step();
    convRes = '0;
  endtask

  task automatic t_regs();
    chk(lowPowerModeEnable, 1'b0);
    bus(1'b0, 4'h0, 8'hBA, 8'h00);
    chk(sfrRdata, 8'h00);
    bus(1'b0, 4'hF, 8'hBA, 8'h00);
    chk(sfrRdata, 8'h0F);
    bus(1'b0, 4'h0, 8'h55, 8'h00);
    chk(sfrRdata, 8'h00);
    bus(1'b1, 4'h0, 8'hBA, 8'hC0);
    bus(1'b0, 4'h0, 8'hBA, 8'h00);
    chk(sfrRdata, 8'h80);
    chk(twelveBitModeEnable, 1'b1);
    bus(1'b1, 4'h0, 8'hBA, 8'h00);
    chk(twelveBitModeEnable, 1'b0);
    bus(1'b1, 4'hF, 8'hBA, 8'hFF);
    bus(1'b0, 4'hF, 8'hBA, 8'h00);
    chk(sfrRdata, 8'h8F);
    chk(lowPowerModeEnable, 1'b1);
    bus(1'b1, 4'hF, 8'hBA, 8'h0F);
    chk(lowPowerModeEnable, 1'b0);
  endtask

  task automatic t_single();
    soc();
    repeat (5) begin
      step();
      chk(convStart, 1'b0);
    end
    chk(convPowered, 1'b0);
    converterEnable = 1'b1;
    step();
    step();
    chk(convPowered, 1'b1);
    soc();
    waitStart();
    done(12'h123);
    soc();
    waitStart();
    done(12'h045);
    rdAcc();
    chk(accRd, 16'h0045);
    bus(1'b1, 4'h0, 8'hBA, 8'h40);
    soc();
    waitStart();
    done(12'h010);
    rdAcc();
    chk(accRd, 16'h0055);
    bus(1'b1, 4'h0, 8'hBE, 8'h00);
    bus(1'b1, 4'h0, 8'hBD, 8'h00);
    soc();
    waitStart();
    done(12'h007);
    rdAcc();
    chk(accRd, 16'h0007);
    bus(1'b1, 4'h0, 8'hBA, 8'h00);
  endtask

  task automatic t_fmt();
    bus(1'b1, 4'h0, 8'hBE, 8'h0A);
    bus(1'b1, 4'h0, 8'hBD, 8'hBC);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 4'h0, 8'hBA, 8'(s << 3));
      rdAcc();
      chk(accRd, 16'h0ABC >> s);
    end
    bus(1'b1, 4'h0, 8'hBA, 8'hA0);
    rdAcc();
    chk(accRd, 16'hABC0);
    bus(1'b1, 4'h0, 8'hBA, 8'h20);
    rdAcc();
    chk(accRd, 16'hAF00);
    bus(1'b1, 4'h0, 8'hBA, 8'h28);
    rdAcc();
    chk(accRd, 16'h0ABC);
    bus(1'b1, 4'h0, 8'hBA, 8'h38);
    rdAcc();
    chk(accRd, 16'h0ABC);
    bus(1'b1, 4'h0, 8'hBA, 8'h00);
  endtask

  task automatic t_warm();
    int cnt[7] = '{1, 4, 8, 16, 32, 64, 1};
    burstModeEnable = 1'b1;
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, 4'h0, 8'hBA, 8'(c));
      soc();
      for (int i = 0; i < cnt[c]; i++) begin
        waitStart();
        if (i == 0) chk(16'(nWait), 16'h0000);
        chk(firstOfBurst, i == 0);
        done(12'(i + 1));
      end
      repeat (4) begin
        step();
        chk(convStart, 1'b0);
      end
      rdAcc();
      chk(accRd, 16'(cnt[c] * (cnt[c] + 1) / 2));
      chk(convPowered, 1'b1);
    end
    bus(1'b1, 4'h0, 8'hBA, 8'h00);
  endtask

  task automatic t_cold();
    int pw[3] = '{0, 1, 4};
    converterEnable = 1'b0;
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, 4'hF, 8'hBA, 8'(pw[p]));
      soc();
      waitStart();
      chk(16'(nWait), 16'((pw[p] + 1) * aab_pkg::PWR_STEP_CYC));
      if (pw[p] == 4) begin
        chk(16'(nWait * aab_pkg::CLK_PERIOD_NS), 16'h07D0);
      end
      chk(firstOfBurst, 1'b1);
      done(12'h001);
      step();
      step();
      chk(convPowered, 1'b0);
    end
  endtask

  task automatic finish_test();
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    err_total++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    sfrReq = '0;
    burstModeEnable = 1'b0;
    converterEnable = 1'b0;
    socPulse = 1'b0;
    convRes = '0;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_regs();
    t_single();
    t_fmt();
    t_warm();
    t_cold();
    finish_test();
  end
endmodule // tb_aab_burst_ctrl
